// ==== inc/frwk_pkg.sv ====
// Function
// - Source registers ignore every host write.
// - Active flag sets when selected combination holds.
// - Generator interrupt follows its active flag.
// - Axis high event when magnitude reaches or exceeds threshold.
// - Axis low event when magnitude below threshold.
// - Source holds six axis flags, active flag.
// - Latched keeps trigger events, else current events.
// - Source read clears register, interrupt, unfreezes.
// - Reset select zero clears counter when inactive.
// - Reset select one decrements counter when inactive.
// - Event asserted after programmed minimum duration.
// - At 400 Hz each count is 2.5 ms.
// - At 100 Hz each count is 10 ms.
// - Counter frozen when latched and event occurred.
// - Combine select zero ORs, one ANDs events.
// - Latch select holds request until source read.
// - Six enable bits admit axis events, reset zero.
// - Two identical, fully independent generators.
// - Either generator routes to either interrupt pin.
// - Second threshold register behaves like first.
// - High is greater-or-equal, low strictly lower.
// - Unlatched interrupt follows the condition directly.
package frwk_pkg;

	localparam logic [7:0] ADDR_IRQ1_CFG = 8'h30;
	localparam logic [7:0] ADDR_IRQ1_SRC = 8'h31;
	localparam logic [7:0] ADDR_IRQ1_THS = 8'h32;
	localparam logic [7:0] ADDR_IRQ1_DUR = 8'h33;
	localparam logic [7:0] ADDR_IRQ2_CFG = 8'h34;
	localparam logic [7:0] ADDR_IRQ2_SRC = 8'h35;
	localparam logic [7:0] ADDR_IRQ2_THS = 8'h36;
	localparam logic [7:0] ADDR_IRQ2_DUR = 8'h37;

	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] THS_RESET = 8'h00;
	localparam logic [7:0] DUR_RESET = 8'h00;
	localparam logic [7:0] SRC_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	localparam int CFG_COMBINE_BIT = 7;
	localparam int CFG_LATCH_BIT = 6;
	localparam int THS_DCRS_BIT = 7;
	localparam int SRC_ACTIVE_BIT = 6;

	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_100_US = 10000;
	localparam int STEP_400_US = 2500;
	localparam int STEP_100_CYC = STEP_100_US * 1000 / CLK_PERIOD_NS;
	localparam int STEP_400_CYC = STEP_400_US * 1000 / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 19;

	function automatic logic [7:0] frwk_magnitude(input logic [7:0] s);
		frwk_magnitude = s[7] ? 8'(-s) : s;
	endfunction

endpackage

// ==== inc/frwk_gen_if.sv ====
`timescale 1ns/100ps
interface frwk_gen_if;
	logic [7:0] cfg;
	logic [7:0] ths;
	logic [7:0] dur;
	logic       tick;
	logic [7:0] acc_x;
	logic [7:0] acc_y;
	logic [7:0] acc_z;
	logic       src_rd;
	logic [7:0] src;

	modport gen
	(
		input  cfg, ths, dur, tick, acc_x, acc_y, acc_z, src_rd,
		output src
	);
	modport ctrl
	(
		output cfg, ths, dur, tick, acc_x, acc_y, acc_z, src_rd,
		input  src
	);
endinterface

// ==== core/frwk_generator.sv ====
`timescale 1ns/100ps
module frwk_generator
	import frwk_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	frwk_gen_if.gen   gif
);

	logic [7:0] cnt_reg;
	logic [7:0] src_reg;
	logic [7:0] mag_x;
	logic [7:0] mag_y;
	logic [7:0] mag_z;
	logic [7:0] thr;
	logic [5:0] events;
	logic [5:0] sel;
	logic       cond;
	logic       recog;
	logic       latch;
	logic       frozen;

	assign latch = gif.cfg[CFG_LATCH_BIT];
	assign thr = {1'b0, gif.ths[6:0]};

	always_comb
	begin
		mag_x = frwk_magnitude(gif.acc_x);
		mag_y = frwk_magnitude(gif.acc_y);
		mag_z = frwk_magnitude(gif.acc_z);
		events[5] = mag_z >= thr;
		events[4] = mag_z < thr;
		events[3] = mag_y >= thr;
		events[2] = mag_y < thr;
		events[1] = mag_x >= thr;
		events[0] = mag_x < thr;
		sel = events & gif.cfg[5:0];
		if (gif.cfg[CFG_COMBINE_BIT])
			cond = (gif.cfg[5:0] != 6'h00) && (sel == gif.cfg[5:0]);
		else
			cond = |sel;
	end

	assign recog = cond && (cnt_reg >= gif.dur);
	assign frozen = latch && src_reg[SRC_ACTIVE_BIT];

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_reg <= DUR_RESET;
		else if (gif.tick && !frozen)
		begin
			if (cond)
			begin
				if (cnt_reg < gif.dur)
					cnt_reg <= cnt_reg + 8'h01;
			end
			else if (gif.ths[THS_DCRS_BIT])
			begin
				if (cnt_reg != 8'h00)
					cnt_reg <= cnt_reg - 8'h01;
			end
			else
				cnt_reg <= 8'h00;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			src_reg <= SRC_RESET;
		else if (gif.tick && !frozen && (recog || !latch))
			src_reg <= recog ? {2'b01, sel} : SRC_RESET;
		else if (gif.src_rd)
			src_reg <= SRC_RESET;
	end

	assign gif.src = src_reg;

endmodule

// ==== core/frwk_top.sv ====
`timescale 1ns/100ps
module frwk_top
	import frwk_pkg::*;
#(
	parameter int STEP_100_CYCLES = STEP_100_CYC,
	parameter int STEP_400_CYCLES = STEP_400_CYC
)
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       link_clk_in,
	input  wire logic       host_req_in,
	input  wire logic       host_wr_in,
	input  wire logic [7:0] host_addr_in,
	input  wire logic [7:0] host_wdata_in,
	output logic            host_ack_out,
	output logic      [7:0] host_rdata_out,
	input  wire logic       sample_rate_in,
	input  wire logic [7:0] accel_x_in,
	input  wire logic [7:0] accel_y_in,
	input  wire logic [7:0] accel_z_in,
	input  wire logic [1:0] route_a_in,
	input  wire logic [1:0] route_b_in,
	output logic            irq_pin_a_out,
	output logic            irq_pin_b_out
);

	// Core reset release.
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// Link reset release.
	logic lrst_meta_reg;
	logic lrst_n;

	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			lrst_meta_reg <= 1'b0;
			lrst_n <= 1'b0;
		end
		else
		begin
			lrst_meta_reg <= 1'b1;
			lrst_n <= lrst_meta_reg;
		end
	end

	// Link side: capture the request and hand it over by toggle.
	logic       busy_reg;
	logic       req_tgl_reg;
	logic       hold_wr_reg;
	logic [7:0] hold_addr_reg;
	logic [7:0] hold_wdata_reg;
	logic       ack_tgl_reg;
	logic [7:0] rdata_reg;
	logic       ack_meta_reg;
	logic       ack_sync_reg;
	logic       ack_seen_reg;
	logic       ack_edge;

	assign ack_edge = ack_sync_reg ^ ack_seen_reg;

	always_ff @(posedge link_clk_in or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			ack_meta_reg <= 1'b0;
			ack_sync_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
		end
		else
		begin
			ack_meta_reg <= ack_tgl_reg;
			ack_sync_reg <= ack_meta_reg;
			ack_seen_reg <= ack_sync_reg;
		end
	end

	always_ff @(posedge link_clk_in or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			busy_reg <= 1'b0;
			req_tgl_reg <= 1'b0;
			hold_wr_reg <= 1'b0;
			hold_addr_reg <= 8'h00;
			hold_wdata_reg <= 8'h00;
		end
		else if (host_req_in && !busy_reg && !host_ack_out)
		begin
			busy_reg <= 1'b1;
			req_tgl_reg <= ~req_tgl_reg;
			hold_wr_reg <= host_wr_in;
			hold_addr_reg <= host_addr_in;
			hold_wdata_reg <= host_wdata_in;
		end
		else if (ack_edge)
			busy_reg <= 1'b0;
	end

	always_ff @(posedge link_clk_in or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			host_ack_out <= 1'b0;
			host_rdata_out <= 8'h00;
		end
		else if (ack_edge)
		begin
			host_ack_out <= 1'b1;
			host_rdata_out <= rdata_reg;
		end
		else if (!host_req_in)
			host_ack_out <= 1'b0;
	end

	// Core side: detect the request toggle.
	logic req_meta_reg;
	logic req_sync_reg;
	logic req_seen_reg;
	logic req_edge;

	assign req_edge = req_sync_reg ^ req_seen_reg;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			req_seen_reg <= 1'b0;
		end
		else
		begin
			req_meta_reg <= req_tgl_reg;
			req_sync_reg <= req_meta_reg;
			req_seen_reg <= req_sync_reg;
		end
	end

	// Register file.
	logic [7:0] cfg1_reg;
	logic [7:0] ths1_reg;
	logic [7:0] dur1_reg;
	logic [7:0] cfg2_reg;
	logic [7:0] ths2_reg;
	logic [7:0] dur2_reg;
	logic       src1_rd_reg;
	logic       src2_rd_reg;
	logic       do_wr;
	logic       do_rd;

	frwk_gen_if g1 ();
	frwk_gen_if g2 ();

	assign do_wr = req_edge && hold_wr_reg;
	assign do_rd = req_edge && !hold_wr_reg;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg1_reg <= CFG_RESET;
			ths1_reg <= THS_RESET;
			dur1_reg <= DUR_RESET;
			cfg2_reg <= CFG_RESET;
			ths2_reg <= THS_RESET;
			dur2_reg <= DUR_RESET;
		end
		else if (do_wr)
		begin
			case (hold_addr_reg)
				ADDR_IRQ1_CFG: cfg1_reg <= hold_wdata_reg;
				ADDR_IRQ1_THS: ths1_reg <= hold_wdata_reg;
				ADDR_IRQ1_DUR: dur1_reg <= hold_wdata_reg;
				ADDR_IRQ2_CFG: cfg2_reg <= hold_wdata_reg;
				ADDR_IRQ2_THS: ths2_reg <= hold_wdata_reg;
				ADDR_IRQ2_DUR: dur2_reg <= hold_wdata_reg;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_reg <= RDATA_UNMAPPED;
			ack_tgl_reg <= 1'b0;
		end
		else if (req_edge)
		begin
			ack_tgl_reg <= ~ack_tgl_reg;
			if (!hold_wr_reg)
			begin
				case (hold_addr_reg)
					ADDR_IRQ1_CFG: rdata_reg <= cfg1_reg;
					ADDR_IRQ1_SRC: rdata_reg <= g1.src;
					ADDR_IRQ1_THS: rdata_reg <= ths1_reg;
					ADDR_IRQ1_DUR: rdata_reg <= dur1_reg;
					ADDR_IRQ2_CFG: rdata_reg <= cfg2_reg;
					ADDR_IRQ2_SRC: rdata_reg <= g2.src;
					ADDR_IRQ2_THS: rdata_reg <= ths2_reg;
					ADDR_IRQ2_DUR: rdata_reg <= dur2_reg;
					default: rdata_reg <= RDATA_UNMAPPED;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src1_rd_reg <= 1'b0;
			src2_rd_reg <= 1'b0;
		end
		else
		begin
			src1_rd_reg <= do_rd && (hold_addr_reg == ADDR_IRQ1_SRC);
			src2_rd_reg <= do_rd && (hold_addr_reg == ADDR_IRQ2_SRC);
		end
	end

	// The rate select pin passes two flip-flops first.
	logic rate_meta_reg;
	logic rate_sync_reg;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rate_meta_reg <= 1'b0;
			rate_sync_reg <= 1'b0;
		end
		else
		begin
			rate_meta_reg <= sample_rate_in;
			rate_sync_reg <= rate_meta_reg;
		end
	end

	// Sample tick at the selected output data rate.
	logic [TICK_CNT_W-1:0] tick_cnt_reg;
	logic [TICK_CNT_W-1:0] tick_last_reg;
	logic                  tick_reg;

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
			tick_last_reg <= TICK_CNT_W'(STEP_100_CYCLES - 1);
		else if (rate_sync_reg)
			tick_last_reg <= TICK_CNT_W'(STEP_400_CYCLES - 1);
		else
			tick_last_reg <= TICK_CNT_W'(STEP_100_CYCLES - 1);
	end

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (tick_cnt_reg >= tick_last_reg)
		begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + TICK_CNT_W'(1);
			tick_reg <= 1'b0;
		end
	end

	// Two independent generators.
	assign g1.cfg = cfg1_reg;
	assign g1.ths = ths1_reg;
	assign g1.dur = dur1_reg;
	assign g1.tick = tick_reg;
	assign g1.acc_x = accel_x_in;
	assign g1.acc_y = accel_y_in;
	assign g1.acc_z = accel_z_in;
	assign g1.src_rd = src1_rd_reg;

	assign g2.cfg = cfg2_reg;
	assign g2.ths = ths2_reg;
	assign g2.dur = dur2_reg;
	assign g2.tick = tick_reg;
	assign g2.acc_x = accel_x_in;
	assign g2.acc_y = accel_y_in;
	assign g2.acc_z = accel_z_in;
	assign g2.src_rd = src2_rd_reg;

	frwk_generator u_gen1
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.gif      (g1.gen)
	);

	frwk_generator u_gen2
	(
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.gif      (g2.gen)
	);

	// Interrupt pin routing.
	logic [1:0] irq_vec;

	assign irq_vec = {g2.src[SRC_ACTIVE_BIT], g1.src[SRC_ACTIVE_BIT]};

	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pin_a_out <= 1'b0;
			irq_pin_b_out <= 1'b0;
		end
		else
		begin
			irq_pin_a_out <= |(irq_vec & route_a_in);
			irq_pin_b_out <= |(irq_vec & route_b_in);
		end
	end

endmodule

// ==== bench/frwk_top_sva.sv ====
`timescale 1ns/100ps
module frwk_top_sva
(
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       link_clk_in,
	input wire logic       host_req_in,
	input wire logic       host_ack_out,
	input wire logic [7:0] host_rdata_out,
	input wire logic [1:0] route_a_in,
	input wire logic [1:0] route_b_in,
	input wire logic       irq_pin_a_out,
	input wire logic       irq_pin_b_out
);
	sequence s_req_start;
		$rose(host_req_in);
	endsequence
	sequence s_a_off;
		(route_a_in == 2'h0) [*3];
	endsequence
	sequence s_b_off;
		(route_b_in == 2'h0) [*3];
	endsequence
	a_ack_bound: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) s_req_start |-> ##[3:8] host_ack_out)
		else $error("ack late");
	a_ack_order: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) $rose(host_ack_out) |-> host_req_in)
		else $error("ack without request");
	a_ack_hold: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) host_ack_out && host_req_in |=> host_ack_out)
		else $error("ack dropped early");
	a_ack_release: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in) host_ack_out && !host_req_in |=> !host_ack_out)
		else $error("ack not released");
	a_rdata_hold: assert property (@(posedge link_clk_in)
		disable iff (!rst_n_in)
		host_ack_out && $past(host_ack_out) |-> $stable(host_rdata_out))
		else $error("read data moved");
	a_pin_a_off: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) s_a_off |-> !irq_pin_a_out)
		else $error("pin a unrouted but high");
	a_pin_b_off: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) s_b_off |-> !irq_pin_b_out)
		else $error("pin b unrouted but high");
	a_pins_agree: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) (route_a_in == route_b_in) [*3]
		|-> irq_pin_a_out == irq_pin_b_out)
		else $error("pins differ on same route");
endmodule

bind frwk_top frwk_top_sva u_sva
(
	.clk_in, .rst_n_in, .link_clk_in, .host_req_in, .host_ack_out,
	.host_rdata_out, .route_a_in, .route_b_in, .irq_pin_a_out, .irq_pin_b_out
);

// ==== bench/frwk_host_model.sv ====
`timescale 1ns/100ps
module frwk_host_model
(
	input  wire logic       link_clk_in,
	input  wire logic       ack_in,
	output logic            req_out,
	output logic            wr_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out
);
	initial
	begin
		req_out = 1'b0;
		wr_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic ok);
		int n;
		int m;
		@(posedge link_clk_in);
		#1;
		wr_out = w;
		addr_out = a;
		wdata_out = d;
		req_out = 1'b1;
		n = 0;
		while (ack_in !== 1'b1 && n < 16)
		begin
			@(posedge link_clk_in);
			n++;
		end
		#1;
		req_out = 1'b0;
		wr_out = ~w;
		addr_out = ~a;
		wdata_out = ~d;
		m = 0;
		while (ack_in !== 1'b0 && m < 16)
		begin
			@(posedge link_clk_in);
			m++;
		end
		ok = (n < 16) && (m < 16);
	endtask
endmodule

// ==== bench/freefall_wakeup_irq_gen_bench.sv ====
`timescale 1ns/100ps
module freefall_wakeup_irq_gen_bench
	import frwk_pkg::*;
;
	localparam int P1 = 40;
	localparam int P4 = 20;
	logic       clk = 1'b0;
	logic       lclk = 1'b0;
	logic       rst_n = 1'b0;
	logic       rate = 1'b0;
	logic [7:0] ax = 8'h00;
	logic [7:0] ay = 8'h00;
	logic [7:0] az = 8'h00;
	logic [1:0] ra = 2'h0;
	logic [1:0] rb = 2'h0;
	logic       ack_d = 1'b0;
	logic       req, wr, ack, pa, pb, ok;
	logic [7:0] addr, wdata, rdata, v;
	logic [7:0] q[$];
	int         seed = 32'hdc44;
	int         fail_count = 0;
	int         total_checks = 0;
	int         i;

	always #12.5 clk = ~clk;
	always #32 lclk = ~lclk;

	frwk_top #(.STEP_100_CYCLES(P1), .STEP_400_CYCLES(P4)) DUT
	(
		.clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk),
		.host_req_in(req), .host_wr_in(wr), .host_addr_in(addr),
		.host_wdata_in(wdata), .host_ack_out(ack), .host_rdata_out(rdata),
		.sample_rate_in(rate), .accel_x_in(ax), .accel_y_in(ay),
		.accel_z_in(az), .route_a_in(ra), .route_b_in(rb),
		.irq_pin_a_out(pa), .irq_pin_b_out(pb)
	);
	frwk_host_model host
	(
		.link_clk_in(lclk), .ack_in(ack), .req_out(req), .wr_out(wr),
		.addr_out(addr), .wdata_out(wdata)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (q.size() != 0)
			fail_count++;
		$display("checks=%0d fails=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		host.access(w, a, d, ok);
		if (!ok)
		begin
			fail_count++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic drive(input logic r, input logic [1:0] a,
		input logic [1:0] b, input logic [7:0] x, input logic [7:0] y,
		input logic [7:0] z);
		@(posedge clk);
		#1;
		rate = r;
		ra = a;
		rb = b;
		ax = x;
		ay = y;
		az = z;
	endtask
	task automatic wait_pin(input bit b, input logic e, input int lim);
		int n;
		n = 0;
		while ((b ? pb : pa) !== e && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if ((b ? pb : pa) !== e)
		begin
			fail_count++;
			print_verdict();
		end
		check({7'h00, (b ? pb : pa)}, {7'h00, e});
	endtask

	// Each read answer is matched against the oldest noted expectation.
	always @(posedge lclk)
	begin
		ack_d <= ack;
		if (ack === 1'b1 && ack_d !== 1'b1 && wr === 1'b0 && q.size() > 0)
			check(rdata, q.pop_front());
	end

	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge lclk);
		for (i = 0; i < 8; i++)
			rd(ADDR_IRQ1_CFG + 8'(i), 8'h00);
		rd(8'h40, RDATA_UNMAPPED);
		for (i = 0; i < 4; i++)
		begin
			v = 8'($random(seed));
			acc(1'b1, 8'h32 + 8'(i % 2 + i / 2 * 4), v);
			rd(8'h32 + 8'(i % 2 + i / 2 * 4), v);
		end
		acc(1'b1, ADDR_IRQ1_SRC, 8'hff);
		acc(1'b1, ADDR_IRQ2_SRC, 8'hff);
		rd(ADDR_IRQ1_SRC, 8'h00);
		rd(ADDR_IRQ2_SRC, 8'h00);
		acc(1'b1, ADDR_IRQ1_CFG, 8'h02);
		acc(1'b1, ADDR_IRQ1_THS, 8'h10);
		acc(1'b1, ADDR_IRQ1_DUR, 8'h00);
		drive(1'b1, 2'h1, 2'h0, 8'hf0, 8'($random(seed)), 8'($random(seed)));
		wait_pin(1'b0, 1'b1, 2 * P4 + 8);
		rd(ADDR_IRQ1_SRC, 8'h42);
		drive(1'b1, 2'h1, 2'h0, 8'h0f, 8'($random(seed)), 8'h00);
		wait_pin(1'b0, 1'b0, 2 * P4 + 8);
		rd(ADDR_IRQ1_SRC, 8'h00);
		acc(1'b1, ADDR_IRQ2_CFG, 8'hd5);
		acc(1'b1, ADDR_IRQ2_THS, 8'h20);
		acc(1'b1, ADDR_IRQ2_DUR, 8'h00);
		drive(1'b1, 2'h0, 2'h2, 8'h05, 8'hfb, 8'h00);
		wait_pin(1'b1, 1'b1, 2 * P4 + 8);
		drive(1'b1, 2'h0, 2'h2, 8'h30, 8'hfb, 8'h00);
		repeat (3 * P4) @(posedge clk);
		check({7'h00, pb}, 8'h01);
		rd(ADDR_IRQ1_SRC, 8'h42);
		rd(ADDR_IRQ2_SRC, 8'h55);
		wait_pin(1'b1, 1'b0, 2 * P4 + 8);
		rd(ADDR_IRQ2_SRC, 8'h00);
		drive(1'b0, 2'h1, 2'h0, 8'h30, 8'h00, 8'h00);
		wait_pin(1'b0, 1'b1, 2 * P1 + 8);
		drive(1'b0, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		wait_pin(1'b0, 1'b0, 2 * P1 + 8);
		acc(1'b1, ADDR_IRQ1_DUR, 8'h03);
		drive(1'b0, 2'h1, 2'h0, 8'h40, 8'h00, 8'h00);
		repeat (2 * P1) @(posedge clk);
		check({7'h00, pa}, 8'h00);
		wait_pin(1'b0, 1'b1, 2 * P1 + 8);
		acc(1'b1, ADDR_IRQ1_THS, 8'h90);
		drive(1'b1, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		wait_pin(1'b0, 1'b0, 2 * P4 + 8);
		drive(1'b1, 2'h1, 2'h0, 8'h40, 8'h00, 8'h00);
		wait_pin(1'b0, 1'b1, 2 * P4 + 8);
		acc(1'b1, ADDR_IRQ1_THS, 8'h10);
		drive(1'b1, 2'h1, 2'h0, 8'h00, 8'h00, 8'h00);
		wait_pin(1'b0, 1'b0, 2 * P4 + 8);
		drive(1'b1, 2'h1, 2'h0, 8'h40, 8'h00, 8'h00);
		repeat (2 * P4 + 8) @(posedge clk);
		check({7'h00, pa}, 8'h00);
		wait_pin(1'b0, 1'b1, 2 * P4 + 8);
		repeat (4) @(posedge lclk);
		print_verdict();
	end
endmodule
